// *** smt_consts.svh ***
// smt_consts.svh: offsets, reset values and cycle counts for the static sequencer
// assumes: included by smt_pkg.sv only; the sequencer relies on that include, no other dependencies
`ifndef SMT_CONSTS_SVH
`define SMT_CONSTS_SVH
`define SMT_CLK_PERIOD_NS 40
`define SMT_PROC_CYCLES 3'h1
`define SMT_ARB_CYCLES 3'h1
`define SMT_CTRL_CYCLES 3'h2
`define SMT_TURN_W 5
`define SMT_TURN_MAX 5'h10
`define SMT_TURN_MIN 5'h01
`define SMT_TURN_RST 5'h00
`define SMT_WR_DRAIN 5'h05
`endif

// *** smt_pkg.sv ***
// smt_pkg.sv: types for the static memory turnaround sequencer
// assumes: smt_consts.svh is on the include path
`include "smt_consts.svh"
package smt_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PROC, ST_ARB, ST_CTRL, ST_TURN, ST_RD_ADDR, ST_RD_SAMPLE, ST_RD_RET,
    ST_WR_SETUP, ST_WR_STROBE, ST_WR_HOLD, ST_WR_IDLE
  } seq_state_e;
  typedef struct packed {
    logic write;
    logic [1:0] bank;
    logic [23:0] addr;
    logic [31:0] wdata;
  } mem_req_s;
  typedef struct packed {
    logic [23:0] addr;
    logic [3:0] cs_n;
    logic oe_n;
    logic we_n;
    logic [31:0] dout;
    logic dout_en;
  } mem_pins_s;
endpackage : smt_pkg

// *** static_mem_turnaround_seq.sv ***
// static_mem_turnaround_seq.sv: static memory cycle sequencer with bus turnaround
// assumes: port arbiter presents one request at a time; rdata pins are asynchronous
// Function
// - accept: process, arbitrate, two internal cycles
// - read sample next cycle, return after
// - write: setup, strobe one cycle, release
// - write then read: twelve read waits
// - read waits at least six, writes none
// - turnaround two: data on first, accept after
// - next address accepted during write setup
// - controls inactive one cycle after write
// - per-bank turnaround of 1 to 16 cycles
// - turnaround read-read diff bank, read-write
`timescale 1ns/1ps
`default_nettype none
module static_mem_turnaround_seq
  import smt_pkg::*;
#(
  parameter int BANKS = 4
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic req_valid, // request from port arbiter
  input var mem_req_s req, // request contents
  output logic req_ready, // request accepted this cycle
  output logic rd_valid, // read data to ahb, one cycle
  output logic [31:0] rd_data, // returned read data
  input wire logic [4*BANKS-1:0] bus_turnaround_cycles, // per-bank turnaround, 4 bits each
  input wire logic [31:0] mem_din, // memory data pins in
  output mem_pins_s pins // memory address, controls, data out
);
  seq_state_e state_r;
  mem_req_s cur_r;
  logic [1:0] cnt_r;
  logic [`SMT_TURN_W-1:0] turn_r;
  logic last_rd_r;
  logic [1:0] last_bank_r;
  logic [31:0] rdata_r;

  // turnaround field 0..15 encodes 1..16 cycles
  function automatic logic [`SMT_TURN_W-1:0] turn_of(input logic [4*BANKS-1:0] f, input logic [1:0] b);
    turn_of = {1'b0, f[4*b +: 4]} + `SMT_TURN_MIN;
  endfunction : turn_of

  // turnaround needed unless read-read same bank or write first
  function automatic logic need_turn(input logic lrd, input logic [1:0] lb, input mem_req_s r);
    need_turn = lrd && (r.write || (r.bank != lb));
  endfunction : need_turn

  // read data is launched by our own registered controls, so it is taken
  // without a synchroniser; two extra flops would break the read timing
  // main sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      cnt_r <= 2'h0;
      turn_r <= `SMT_TURN_RST;
      last_rd_r <= 1'b0;
      last_bank_r <= 2'h0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // a request that needs turnaround waits until the last turnaround cycle
          if (req_valid && !req_ready &&
              (turn_r <= `SMT_TURN_MIN || !need_turn(last_rd_r, last_bank_r, req))) begin
            cur_r <= req;
            req_ready <= 1'b1;
            turn_r <= `SMT_TURN_RST;
            state_r <= ST_PROC;
          end else if (turn_r != `SMT_TURN_RST) begin
            turn_r <= turn_r - `SMT_TURN_MIN;
          end
        end
        ST_PROC: state_r <= ST_ARB;
        ST_ARB: begin
          cnt_r <= 2'h0;
          state_r <= ST_CTRL;
        end
        ST_TURN: begin
          // drain a finished write before a request taken early goes out
          if (turn_r <= `SMT_TURN_MIN) begin
            turn_r <= `SMT_TURN_RST;
            cnt_r <= 2'h0;
            state_r <= ST_CTRL;
          end else begin
            turn_r <= turn_r - `SMT_TURN_MIN;
          end
        end
        ST_CTRL: begin
          cnt_r <= cnt_r + 2'h1;
          if (cnt_r == 2'(`SMT_CTRL_CYCLES - 3'h1)) begin
            state_r <= cur_r.write ? ST_WR_SETUP : ST_RD_ADDR;
          end
        end
        ST_RD_ADDR: state_r <= ST_RD_SAMPLE;
        ST_RD_SAMPLE: state_r <= ST_RD_RET;
        ST_RD_RET: begin
          last_rd_r <= 1'b1;
          last_bank_r <= cur_r.bank;
          // turnaround runs from the return cycle on; data goes out in its first cycle
          turn_r <= turn_of(bus_turnaround_cycles, cur_r.bank) - `SMT_TURN_MIN;
          state_r <= ST_IDLE;
        end
        ST_WR_SETUP: begin
          // next address may be taken while the write is still on the pins
          if (req_valid) begin
            cur_r <= req;
            req_ready <= 1'b1;
          end
          state_r <= ST_WR_STROBE;
        end
        ST_WR_STROBE: state_r <= ST_WR_HOLD;
        ST_WR_HOLD: state_r <= ST_WR_IDLE;
        ST_WR_IDLE: begin
          last_rd_r <= 1'b0;
          // a request taken early waits five cycles for the write to finish
          if (pend_r) begin
            turn_r <= `SMT_WR_DRAIN;
            state_r <= ST_TURN;
          end else begin
            turn_r <= `SMT_TURN_RST;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // a write-then-read pair: early request queued, rerun from the control cycles
  logic pend_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 1'b0;
    end else if (state_r == ST_WR_SETUP && req_valid) begin
      pend_r <= 1'b1;
    end else if (state_r == ST_WR_IDLE) begin
      pend_r <= 1'b0;
    end
  end

  // read data capture and return to ahb, one cycle pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      rd_valid <= 1'b0;
      if (state_r == ST_RD_SAMPLE) begin
        rdata_r <= mem_din;
      end
      if (state_r == ST_RD_RET) begin
        rd_valid <= 1'b1;
        rd_data <= rdata_r;
      end
    end
  end

  // memory pins: write enable low only in the strobe cycle, all off at write idle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pins <= '{addr: 24'h0, cs_n: 4'hF, oe_n: 1'b1, we_n: 1'b1, dout: 32'h0, dout_en: 1'b0};
    end else begin
      pins.cs_n <= 4'hF;
      pins.oe_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.dout_en <= 1'b0;
      if (state_r == ST_CTRL && cnt_r == 2'(`SMT_CTRL_CYCLES - 3'h1)) begin
        pins.addr <= cur_r.addr;
        pins.cs_n <= ~(4'h1 << cur_r.bank);
        pins.oe_n <= cur_r.write;
        pins.dout <= cur_r.wdata;
      end
      if (state_r == ST_RD_ADDR) begin
        pins.cs_n <= ~(4'h1 << cur_r.bank);
        pins.oe_n <= 1'b0;
      end
      if (state_r == ST_WR_SETUP) begin
        pins.cs_n <= ~(4'h1 << cur_r.bank);
        pins.we_n <= 1'b0;
        pins.dout_en <= 1'b1;
      end
      if (state_r == ST_WR_STROBE) begin
        pins.cs_n <= pins.cs_n;
        pins.dout_en <= 1'b1;
      end
    end
  end

  // write strobe is exactly one cycle wide
  we_one_cycle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(pins.we_n) |=> pins.we_n) else $error("write enable longer than one cycle");
  // setup cycle with chip select and we high precedes strobe
  we_setup_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(pins.we_n) |-> $past(pins.cs_n) != 4'hF && $past(pins.we_n)) else $error("no write setup cycle");
  // chip select and write enable idle the cycle after write strobe ends
  wr_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(pins.we_n) |=> pins.cs_n == 4'hF && pins.we_n) else $error("controls not idle after write");
  // accept to pins takes four cycles with no turnaround
  accept_lat_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_r == ST_PROC && !need_turn(last_rd_r, last_bank_r, cur_r) |-> ##4 pins.cs_n != 4'hF)
    else $error("address latency wrong");
  // read data returned three cycles after output enable
  rd_ret_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(pins.oe_n) && state_r == ST_RD_ADDR |-> ##3 rd_valid) else $error("read return late");
  // read data valid is a single-cycle pulse
  rd_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_valid |=> !rd_valid) else $error("read valid longer than one cycle");
  // output and write enables never both active
  ctrl_excl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(!pins.oe_n && !pins.we_n)) else $error("output and write enable both low");
  // no accept while turnaround still has more than one cycle to run
  turn_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_r == ST_IDLE && turn_r > `SMT_TURN_MIN && need_turn(last_rd_r, last_bank_r, req) |=> !req_ready)
    else $error("accepted inside turnaround");
  // no acceptance in the same cycle as the read return pulse
  turn_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_valid |-> !req_ready) else $error("accepted during turnaround");
  // early accept only seen in write setup
  early_acc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    req_ready && $past(state_r) != ST_IDLE |-> $past(state_r) == ST_WR_SETUP) else $error("bad early accept");
  // turnaround counter never exceeds the largest setting
  turn_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    turn_r <= `SMT_TURN_MAX) else $error("turnaround out of range");
  rd_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst) rd_valid);
  wr_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(pins.we_n));
  turn_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst) state_r == ST_TURN);
  early_cov_c: cover property (@(posedge sys_clk) disable iff (!nrst) pend_r);
endmodule : static_mem_turnaround_seq
`default_nettype wire

// *** smt_mem_model.sv ***
// smt_mem_model.sv: behavioural asynchronous static memory at the sequencer pins
// assumes: one shared data bus, low address bits pick the word, no bank decode
`timescale 1ns/1ps
`default_nettype none
module smt_mem_model
  import smt_pkg::*;
(
  input var mem_pins_s pins, // controls from the sequencer
  output logic [31:0] mem_din // read data to the sequencer
);
  logic [31:0] store [0:255];
  logic [31:0] last_r = 32'h0;
  // word stored on the release of we_n, as an async part does
  always @(posedge pins.we_n) begin
    if (pins.cs_n != 4'hF) store[pins.addr[7:0]] <= pins.dout;
  end
  // released bus shows the inverse of the last word, never a stale copy
  always @* begin
    if (pins.cs_n != 4'hF && pins.oe_n == 1'b0) begin
      mem_din = store[pins.addr[7:0]];
      last_r = mem_din;
    end else mem_din = ~last_r;
  end
endmodule : smt_mem_model
`default_nettype wire

// *** static_mem_turnaround_seq_tb_top.sv ***
// static_mem_turnaround_seq_tb_top.sv: directed bench for the static sequencer
// assumes: smt_pkg compiled first, memory model answers at once
`timescale 1ns/1ps
`default_nettype none
module static_mem_turnaround_seq_tb_top;
  import smt_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_ready, rd_valid;
  mem_req_s req = '0;
  logic [31:0] rd_data, mem_din;
  logic [15:0] turn = 16'h17F0; // banks 3..0: 1, 7, F, 0
  mem_pins_s pins;
  int failures = 0, total_checks = 0, n, ga, gb, gc, gd, ge;
  static_mem_turnaround_seq u_static_mem_turnaround_seq (.sys_clk(sys_clk), .nrst(nrst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .bus_turnaround_cycles(turn), .mem_din(mem_din), .pins(pins));
  smt_mem_model u_smt_mem_model (.pins(pins), .mem_din(mem_din));
  // 25 MHz clock
  initial forever #20 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  function automatic bit hit(input int which);
    case (which)
      0: return req_ready === 1'b1;
      1: return pins.cs_n !== 4'hF;
      2: return rd_valid === 1'b1;
      3: return pins.we_n === 1'b0;
      default: return pins.cs_n === 4'hF;
    endcase
  endfunction : hit
  // counts falling edges until the event; a hang ends the run
  task automatic wait_for(input int which, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
      if (cnt > 80) begin
        check(32'h0, 32'h1);
        stop_test();
      end
    end while (!hit(which));
  endtask : wait_for
  task automatic issue(input logic wr, input logic [1:0] bk, input logic [7:0] a);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{wr, bk, {16'h0, a}, {4{a}}};
  endtask : issue
  task automatic drop();
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask : drop
  task automatic t_single();
    issue(1'b1, 2'h0, 8'h21); wait_for(0, n); drop();
    wait_for(1, n); check(n, 4);
    check({pins.cs_n, pins.we_n}, 5'h1D);
    wait_for(3, n); check(n, 1);
    check(pins.dout, 32'h21212121);
    check(pins.dout_en, 1'b1);
    @(negedge sys_clk); check({pins.cs_n, pins.we_n}, 5'h1D);
    @(negedge sys_clk); check({pins.cs_n, pins.oe_n, pins.we_n}, 6'h3F);
    issue(1'b0, 2'h0, 8'h21); wait_for(0, n); drop();
    wait_for(1, n); check({n[3:0], pins.oe_n}, 5'h08);
    wait_for(2, n); check(n, 3);
    check(rd_data, 32'h21212121);
  endtask : t_single
  // read held pending while the write is still on the pins
  task automatic t_wr_rd();
    issue(1'b1, 2'h0, 8'h35); wait_for(0, n);
    issue(1'b0, 2'h0, 8'h35); wait_for(0, n); drop();
    check(pins.cs_n, 4'hE);
    wait_for(2, n); check(n, 13);
    check(rd_data, 32'h35353535);
  endtask : t_wr_rd
  // time from the read's accept to the next request's accept
  task automatic gap(input logic [1:0] b1, input logic w2, input logic [1:0] b2, output int g);
    issue(1'b0, b1, 8'h21); wait_for(0, n);
    issue(w2, b2, 8'h21); wait_for(0, g); drop();
    if (w2) wait_for(3, n);
    else wait_for(2, n);
    wait_for(4, n);
  endtask : gap
  initial begin
    repeat (10) @(posedge sys_clk);
    check({req_ready, rd_valid, pins.cs_n, pins.oe_n, pins.we_n, pins.dout_en}, 9'h07E);
    nrst <= 1'b1;
    t_single();
    t_wr_rd();
    gap(2'h1, 1'b1, 2'h1, ga);
    gap(2'h2, 1'b1, 2'h2, gb);
    gap(2'h1, 1'b0, 2'h2, gc);
    gap(2'h1, 1'b0, 2'h1, gd);
    gap(2'h3, 1'b1, 2'h2, ge);
    check(ga - gb, 8);
    check(gc, ga);
    check(gd < gc, 1);
    check(gb - ge, 6);
    stop_test();
  end
endmodule : static_mem_turnaround_seq_tb_top
`default_nettype wire
